// >>> logic/pwr_seq_pkg.sv
// constants and state encoding for the transmitter power sequencer
// assumes a 250 MHz reference clock; all intervals counted in milliseconds
//
// Contract
// R01: heater start press closes control relay drive to begin start sequence.
// R02: heater relay drive only while air flow and all safety interlocks closed.
// R03: plate power-up needs plate request and heater on at least ten seconds.
// R04: step and start drives gated on heater being active.
// R05: step drive first, start drive 100 ms later.
// R06: step drive released 160 ms after start drive closes.
// R07: interlock open during start aborts sequence; await new manual start.
// R08: interlock open during operation releases every supply drive at once; control drive stays on while the safety interlock is closed.
// R09: prompt interlock reclose restores blower path only; no transmission resume.
// R10: plate stop releases plate and screen drives, heater stays energized.
// R11: heater stop releases all drives except blower and flushing fan path.
// R12: after heater stop keep blower at least 30 seconds then turn off.
// R13: intervals from millisecond tick; reset forces every relay drive inactive.
package pwr_seq_pkg;

    localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam int unsigned WARMUP_MS      = 10_000;
    localparam int unsigned STEP_TO_START_MS = 100;
    localparam int unsigned OVERLAP_MS     = 160;
    localparam int unsigned COOLDOWN_MS    = 30_000;

    localparam int unsigned MS_W = 15;

    typedef enum logic [6:0] {
        ST_OFF     = 7'h01,
        ST_HEAT    = 7'h02,
        ST_STEP    = 7'h04,
        ST_OVERLAP = 7'h08,
        ST_RUN     = 7'h10,
        ST_COOL    = 7'h20,
        ST_TRIP    = 7'h40
    } seq_state_e;

endpackage

// >>> logic/ms_tick_gen.sv
// millisecond tick generator
// assumes a free running clock; ce freezes the count
`timescale 1ns/1ps
module ms_tick_gen
    import pwr_seq_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
)(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic ce,
    // tick out
    output logic      tick
);
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        tick_d = tick_q;
        if (ce)
        begin
            tick_d = (cnt_q == 18'(CYCLES - 1));
            cnt_d  = tick_d ? 18'h00000 : cnt_q + 18'h00001;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_q  <= 18'h00000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // ms_tick_gen

// >>> logic/pwr_seq.sv
// transmitter power sequencer: control, heater, step and start relay drives
// assumes switch and interlock inputs are asynchronous pins, active high
`timescale 1ns/1ps
module pwr_seq
    import pwr_seq_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned WARM_MS  = WARMUP_MS,
    parameter int unsigned COOL_MS  = COOLDOWN_MS
)(
    // clock, reset, enable
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic ce,
    // operator switches, level while pressed
    input  wire logic heater_start_sw,
    input  wire logic heater_stop_sw,
    input  wire logic plate_start_sw,
    input  wire logic plate_stop_sw,
    // interlocks, high when closed
    input  wire logic air_ilk_ok,
    input  wire logic safety_ilk_ok,
    // relay drives
    output logic      control_relay_drive,
    output logic      heater_relay_drive,
    output logic      step_relay_drive,
    output logic      start_relay_drive,
    // status
    output logic      plate_on,
    output logic      tripped
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NIN = 6;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] prev_q;
    logic [NIN-1:0] rise;

    assign raw = {safety_ilk_ok, air_ilk_ok, plate_stop_sw, plate_start_sw,
                  heater_stop_sw, heater_start_sw};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                begin
                    s1_q[gi]   <= 1'b0;
                    s2_q[gi]   <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    s1_q[gi]   <= raw[gi];
                    s2_q[gi]   <= s1_q[gi];
                    prev_q[gi] <= s2_q[gi];
                end
            end
            assign rise[gi] = s2_q[gi] & ~prev_q[gi];
        end
    endgenerate

    logic press_hstart;
    logic press_hstop;
    logic press_pstart;
    logic press_pstop;
    logic air_ok;
    logic safe_ok;
    assign press_hstart = rise[0];
    assign press_hstop  = rise[1];
    assign press_pstart = rise[2];
    assign press_pstop  = rise[3];
    assign air_ok       = s2_q[4];
    assign safe_ok      = s2_q[5];

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    logic tick;

    ms_tick_gen #(
        .CYCLES (TICK_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ce      (ce),
        .tick    (tick)   // R13
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    seq_state_e     st_q;
    seq_state_e     st_d;
    logic [MS_W-1:0] ms_q;
    logic [MS_W-1:0] ms_d;
    logic [MS_W-1:0] warm_q;
    logic [MS_W-1:0] warm_d;
    logic           preq_q;
    logic           preq_d;
    logic           ctl_q;
    logic           ctl_d;
    logic           htr_q;
    logic           htr_d;
    logic           stp_q;
    logic           stp_d;
    logic           srt_q;
    logic           srt_d;
    logic           warm_done;
    logic           ilk_ok;

    assign ilk_ok    = air_ok & safe_ok;
    // strictly above: the first tick may come one cycle after heater-on,
    // so a plain >= would fall short of the minimum warm-up by almost a tick
    assign warm_done = (warm_q > MS_W'(WARM_MS));

    always_comb
    begin
        st_d   = st_q;
        ms_d   = ms_q;
        warm_d = warm_q;
        preq_d = preq_q;
        if (ce)
        begin
            if (tick && ms_q != {MS_W{1'b1}})
                ms_d = ms_q + MS_W'(1);
            // heater time accrues only while heater drive is on
            if (tick && htr_q && !warm_done)
                warm_d = warm_q + MS_W'(1);
            if (press_pstart)
                preq_d = 1'b1;
            case (st_q)
                ST_OFF:
                begin
                    preq_d = 1'b0;
                    warm_d = '0;
                    if (press_hstart)
                        st_d = ST_HEAT;                       // R01
                end
                ST_HEAT:
                begin
                    if (press_hstop)
                    begin
                        st_d = ST_COOL;                       // R11
                        ms_d = '0;
                    end
                    else if (!safe_ok || (htr_q && !air_ok))
                    begin
                        st_d = ST_TRIP;                       // R07
                    end
                    else if (press_pstop)
                        preq_d = 1'b0;
                    else if (preq_q && warm_done && htr_q)
                    begin
                        st_d = ST_STEP;                       // R03 R04
                        ms_d = '0;
                    end
                end
                ST_STEP, ST_OVERLAP, ST_RUN:
                begin
                    if (!ilk_ok)
                        st_d = ST_TRIP;                       // R07 R08
                    else if (press_hstop)
                    begin
                        st_d = ST_COOL;                       // R11
                        ms_d = '0;
                    end
                    else if (press_pstop)
                    begin
                        st_d   = ST_HEAT;                     // R10
                        preq_d = 1'b0;
                    end
                    else if (st_q == ST_STEP && ms_q >= MS_W'(STEP_TO_START_MS))
                    begin
                        st_d = ST_OVERLAP;                    // R05
                        ms_d = '0;
                    end
                    else if (st_q == ST_OVERLAP && ms_q >= MS_W'(OVERLAP_MS))
                        st_d = ST_RUN;                        // R06
                end
                ST_COOL:
                begin
                    // no plate request or warm-up credit survives a heater stop
                    preq_d = 1'b0;
                    warm_d = '0;
                    // strictly above, for the same reason as the warm-up
                    if (ms_q > MS_W'(COOL_MS))
                        st_d = ST_OFF;                        // R12
                    else if (press_hstart && ilk_ok)
                        st_d = ST_HEAT;
                end
                ST_TRIP:
                begin
                    preq_d = 1'b0;
                    warm_d = '0;
                    // restored blower still needs a manual start to resume
                    if (press_hstart && ilk_ok)
                        st_d = ST_HEAT;                       // R09
                    else if (press_hstop)
                    begin
                        st_d = ST_COOL;
                        ms_d = '0;
                    end
                end
                default:
                    st_d = ST_OFF;
            endcase
        end
    end

    always_comb
    begin
        ctl_d = 1'b0;
        htr_d = 1'b0;
        stp_d = 1'b0;
        srt_d = 1'b0;
        case (st_d)
            ST_HEAT:    ctl_d = 1'b1;                          // R01
            ST_STEP:    ctl_d = 1'b1;
            ST_OVERLAP: ctl_d = 1'b1;
            ST_RUN:     ctl_d = 1'b1;
            ST_COOL:    ctl_d = 1'b1;                          // R12
            ST_TRIP:    ctl_d = safe_ok;                       // R08 R09
            default:    ctl_d = 1'b0;
        endcase
        if (st_d inside {ST_HEAT, ST_STEP, ST_OVERLAP, ST_RUN})
            htr_d = ilk_ok;                                    // R02
        stp_d = htr_q & htr_d & (st_d inside {ST_STEP, ST_OVERLAP});  // R04 R05 R06
        srt_d = htr_q & htr_d & (st_d inside {ST_OVERLAP, ST_RUN});   // R04 R05
        if (!ce)
        begin
            ctl_d = ctl_q;
            htr_d = htr_q;
            stp_d = stp_q;
            srt_d = srt_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_q   <= ST_OFF;
            ms_q   <= '0;
            warm_q <= '0;
            preq_q <= 1'b0;
            ctl_q  <= 1'b0;                                    // R13
            htr_q  <= 1'b0;
            stp_q  <= 1'b0;
            srt_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            ms_q   <= ms_d;
            warm_q <= warm_d;
            preq_q <= preq_d;
            ctl_q  <= ctl_d;
            htr_q  <= htr_d;
            stp_q  <= stp_d;
            srt_q  <= srt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, straight from flip-flops
    logic pon_q;
    logic trp_q;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pon_q <= 1'b0;
            trp_q <= 1'b0;
        end
        else if (ce)
        begin
            pon_q <= srt_d;
            trp_q <= (st_d == ST_TRIP);
        end
    end

    assign control_relay_drive = ctl_q;
    assign heater_relay_drive  = htr_q;
    assign step_relay_drive    = stp_q;
    assign start_relay_drive   = srt_q;
    assign plate_on            = pon_q;
    assign tripped             = trp_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_step_alone;
        step_relay_drive && !start_relay_drive;
    endsequence

    a_heater_needs_ilk: assert property (@(posedge ref_clk) disable iff (reset)
        heater_relay_drive |-> $past(ilk_ok))                  // R02
        else $error("heater drive without interlocks");
    a_plate_needs_heat: assert property (@(posedge ref_clk) disable iff (reset)
        (step_relay_drive || start_relay_drive) |-> heater_relay_drive)  // R04
        else $error("plate drive without heater");
    a_step_before_start: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(start_relay_drive) |-> $past(step_relay_drive))  // R05
        else $error("start closed without step");
    a_step_enters_alone: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(step_relay_drive) |-> s_step_alone)              // R05
        else $error("step and start rose together");
    a_plate_warmed: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(step_relay_drive) |-> warm_done)                 // R03
        else $error("plate started before warm-up");
    a_trip_drops_all: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        (st_q == ST_RUN && !safe_ok) |=> !heater_relay_drive && !start_relay_drive
        && !control_relay_drive)                               // R08
        else $error("interlock loss left drives on");
    a_pstop_keeps_heat: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        (st_q == ST_RUN && press_pstop && ilk_ok && !press_hstop) |=>
        !start_relay_drive && heater_relay_drive)              // R10
        else $error("plate stop handled wrongly");
    a_hstop_blower: assert property (@(posedge ref_clk) disable iff (reset || !ce)
        (st_q == ST_HEAT && press_hstop) |=>
        control_relay_drive && !heater_relay_drive)            // R11 R12
        else $error("heater stop handled wrongly");
    a_reset_quiet: assert property (@(posedge ref_clk)
        $past(reset) |-> !control_relay_drive && !heater_relay_drive)  // R13
        else $error("drive on after reset");
endmodule // pwr_seq

// >>> dv/plant_model.sv
// far side of the sequencer: contactors pulled in by the relay drives,
// and the air and safety interlock switches; assumes bench-commanded faults
`timescale 1ns/1ps
module plant_model (
    // clock
    input  wire logic ref_clk,
    // relay drives from the sequencer
    input  wire logic control_relay_drive,
    input  wire logic step_relay_drive,
    input  wire logic start_relay_drive,
    // faults commanded by the bench
    input  wire logic air_fault,
    input  wire logic safety_fault,
    // contacts seen by the sequencer and bench
    output logic      control_contactor,
    output logic      step_contactor,
    output logic      start_contactor,
    output logic      air_ilk_ok,
    output logic      safety_ilk_ok
);
    ////////////////////////////////////////////////////////////////////////////
    // contactors pull in one cycle after their coil is driven
    always_ff @(posedge ref_clk)
    begin
        control_contactor <= control_relay_drive;
        step_contactor    <= step_relay_drive;
        start_contactor   <= start_relay_drive;
    end
    // switches stay closed unless a scenario opens them on purpose
    assign air_ilk_ok    = ~air_fault;
    assign safety_ilk_ok = ~safety_fault;
endmodule // plant_model

// >>> dv/tb_top.sv
// self-checking bench for the power sequencer with shortened intervals
// assumes the plant model closes the interlocks unless a fault is commanded
`timescale 1ns/1ps
module tb_top;
    localparam int TK = 10;
    localparam int WM = 20;
    localparam int CM = 30;
    logic       ref_clk      = 1'b0;
    logic       reset        = 1'b1;
    logic       ce           = 1'b1;
    logic [3:0] sw           = 4'h0; // heater start, heater stop, plate start, stop
    logic       air_fault    = 1'b0;
    logic       safety_fault = 1'b0;
    wire logic  air_ilk_ok;
    wire logic  safety_ilk_ok;
    wire logic [5:0] o; // tripped, plate_on, start, step, heater, control
    int         n_errors     = 0;
    int         comparisons  = 0;
    int         n;
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    pwr_seq #(.TICK_CYC(TK), .WARM_MS(WM), .COOL_MS(CM)) pwr_seq_i (
        .ref_clk(ref_clk), .reset(reset), .ce(ce),
        .heater_start_sw(sw[0]), .heater_stop_sw(sw[1]),
        .plate_start_sw(sw[2]), .plate_stop_sw(sw[3]),
        .air_ilk_ok(air_ilk_ok), .safety_ilk_ok(safety_ilk_ok),
        .control_relay_drive(o[0]), .heater_relay_drive(o[1]),
        .step_relay_drive(o[2]), .start_relay_drive(o[3]),
        .plate_on(o[4]), .tripped(o[5]));
    plant_model plant_model_i (
        .ref_clk(ref_clk), .control_relay_drive(o[0]),
        .step_relay_drive(o[2]), .start_relay_drive(o[3]),
        .air_fault(air_fault), .safety_fault(safety_fault),
        .control_contactor(), .step_contactor(), .start_contactor(),
        .air_ilk_ok(air_ilk_ok), .safety_ilk_ok(safety_ilk_ok));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string nm, logic [5:0] exp, logic [5:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // interval check: a window of one tick plus synchroniser slack
    task automatic rng(string nm, int lo, int hi);
        comparisons++;
        if (n < lo || n > hi)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, n);
        end
    endtask
    // bounded wait on one output bit; n returns the cycles spent
    task automatic wait_bit(int k, logic v, int lim);
        n = 0;
        while (o[k] !== v)
        begin
            @(posedge ref_clk);
            n++;
            if (n > lim)
            begin
                chk("wait bound", 6'h00, 6'h3F);
                end_of_test();
            end
        end
    endtask
    // a press is held long enough to pass the synchroniser
    task automatic press(logic [3:0] s);
        sw <= s;
        repeat (6) @(posedge ref_clk);
        sw <= 4'h0;
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge ref_clk);
        chk("reset drives", 6'h00, o);
        reset <= 1'b0;
        @(posedge ref_clk);
        press(4'h4);
        repeat (20) @(posedge ref_clk);
        chk("plate start while off", 6'h00, o);
        sw <= 4'h1;
        wait_bit(1, 1'b1, 20);
        chk("heater start", 6'h03, o);
        // plate request made at once, held until warm-up has run out
        press(4'h4);
        wait_bit(2, 1'b1, 400);
        n = n + 7;
        rng("warm-up", WM * TK, WM * TK + TK + 8);
        chk("step first", 6'h07, o);
        wait_bit(3, 1'b1, 1100);
        rng("step to start", 100 * TK - 8, 100 * TK + TK + 2);
        chk("overlap", 6'h1F, o);
        wait_bit(2, 1'b0, 1700);
        rng("overlap length", 160 * TK - 8, 160 * TK + TK + 2);
        chk("running", 6'h1B, o);
        press(4'h8);
        repeat (4) @(posedge ref_clk);
        chk("plate stop", 6'h03, o);
        press(4'h2);
        repeat (4) @(posedge ref_clk);
        chk("heater stop", 6'h01, o);
        wait_bit(0, 1'b0, 400);
        n = n + 7;
        rng("cool-down", CM * TK, CM * TK + TK + 8);
        // trip while running, then a prompt reclose
        press(4'h1);
        press(4'h4);
        wait_bit(3, 1'b1, 1400);
        wait_bit(2, 1'b0, 1700);
        safety_fault <= 1'b1;
        wait_bit(5, 1'b1, 10);
        chk("trip in run", 6'h20, o);
        safety_fault <= 1'b0;
        wait_bit(0, 1'b1, 20);
        chk("reclose blower only", 6'h01, o & 6'h0F);
        press(4'h4);
        repeat (300) @(posedge ref_clk);
        chk("no resume", 6'h01, o & 6'h0F);
        // trip during the step interval aborts the start
        press(4'h1);
        chk("restart", 6'h03, o & 6'h0F);
        press(4'h4);
        wait_bit(2, 1'b1, 400);
        safety_fault <= 1'b1;
        wait_bit(2, 1'b0, 10);
        @(posedge ref_clk);
        chk("abort start", 6'h00, o & 6'h0F);
        safety_fault <= 1'b0;
        wait_bit(0, 1'b1, 20);
        repeat (1500) @(posedge ref_clk);
        chk("stays aborted", 6'h01, o & 6'h0F);
        // air interlock loss drops the heater
        press(4'h1);
        air_fault <= 1'b1;
        wait_bit(1, 1'b0, 10);
        chk("air loss", 6'h00, o & 6'h0E);
        // enable low freezes everything, even an interlock loss
        ce           <= 1'b0;
        safety_fault <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk("frozen", 6'h21, o);
        ce <= 1'b1;
        wait_bit(0, 1'b0, 10);
        chk("thawed", 6'h20, o);
        end_of_test();
    end
endmodule // tb_top
